//--- logic/crm_pkg.sv
// Constants and carrier types for the clock, reset and mode select block
package crm_pkg;
  localparam int unsigned        SYNC_STAGES      = 2;
  localparam int unsigned        MCLK_PERIOD_NS   = 10;
  localparam int unsigned        RESET_OUT_DELAY  = 2;
  localparam int unsigned        FETCH_DELAY_CLK  = 7;
  localparam int unsigned        STRAP_WINDOW     = 4;
  localparam int unsigned        WAIT_RESAMPLE    = 5;
  localparam logic [3:0]         CNT_ZERO         = 4'h0;
  localparam logic [3:0]         CNT_ONE          = 4'h1;
  localparam logic [2:0]         WCNT_ZERO        = 3'h0;
  localparam logic [2:0]         WCNT_ONE         = 3'h1;

  typedef enum logic [3:0] {
    CRM_RESET   = 4'h1,
    CRM_RELEASE = 4'h2,
    CRM_RUN     = 4'h4,
    CRM_PAUSED  = 4'h8
  } crm_state_t;

  typedef struct packed {
    logic extended_mode;
    logic fetch_start;
    logic core_run;
    logic suspended;
    logic coproc_busy;
  } crm_status_t;
endpackage

//--- logic/crm_sync.sv
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module crm_sync #(
  parameter int unsigned STAGES = 2,
  parameter logic        INIT   = 1'h0
) (
  input  wire logic mclk,    // System clock
  input  wire logic reset,   // Synchronous reset
  input  wire logic ce,      // Clock enable
  input  wire logic d_in,    // Asynchronous level
  output logic      q_out    // Synchronised level
);
  logic [STAGES-1:0] chain_reg;

  always_ff @(posedge mclk) begin
    if (reset) begin
      chain_reg <= {STAGES{INIT}};
    end else if (ce) begin
      chain_reg <= {chain_reg[STAGES-2:0], d_in};
    end
  end

  assign q_out = chain_reg[STAGES-1];
endmodule // crm_sync

//--- logic/crm_top.sv
// Clock divider, reset sequencing, mode strap and wait gate logic
// How it works
// [R1] System clock output is oscillator input divided by two.
// [R2] System clock output has equal high and low times.
// [R3] System clock output keeps toggling during reset and bus hold.
// [R4] Active low init input aborts activity, clears state, stays idle.
// [R5] Init input is asynchronous and passes a synchroniser first.
// [R6] First fetch starts about six and a half clocks after release.
// [R7] Outside party holds init low over four stable clocks.
// [R8] Extended mode needs strap high at release, low four clocks later.
// [R9] Strap pin is an input from reset; sampled during and after reset.
// [R10] Weak pull-up makes an undriven strap pin read high.
// [R11] Legacy mode uses strap pin as the pause instruction's wait gate.
// [R12] Wait gate high at pause start suspends execution.
// [R13] Suspended core resamples gate every five clocks, resumes when low; code resamples every five oscillator edges.
// [R14] Pending enabled interrupts are still serviced while suspended.
// [R15] Extended mode strap pin carries coprocessor busy, high active.
// [R16] Reset output high, clock synchronous, drops two clocks after release.
// [R17] Reset output tied to strap pin yields extended mode.
// [R18] Divider is one flip-flop toggling on every oscillator rising edge.
// [R19] Strap window counted on oscillator edges, two per output clock, from synchronised release.
`timescale 1ns/1ps
module crm_top (
  input  wire logic          mclk,             // Oscillator input clock (osc_in role)
  input  wire logic          reset,            // Synchronous power-on reset
  input  wire logic          ce,               // Clock enable, freezes state when low
  input  wire logic          external_init_n,  // Asynchronous init request, active low
  input  wire logic          strap_in,         // Strap pin level from pad
  input  wire logic          strap_driven,     // External driver present on strap pin
  input  wire logic          pause_start,      // Pause instruction begins
  input  wire logic          irq_pending,      // Enabled interrupt pending
  output logic               osc_feedback_out, // Oscillator feedback drive
  output logic               system_clock_out, // Divided clock output
  output logic               reset_out,        // System reset output, active high
  output logic               irq_service,      // Take interrupt while suspended
  output crm_pkg::crm_status_t status          // Mode, run and wait status
);
  logic                 clk_div_reg;
  logic                 init_sync;
  logic                 init_sync_d_reg;
  logic                 reset_out_reg;
  logic [3:0]           rel_cnt_reg;
  logic [3:0]           rel_cnt_next;
  logic [2:0]           wait_cnt_reg;
  logic                 strap_hi_reg;
  logic                 ext_mode_reg;
  logic                 fetch_reg;
  crm_pkg::crm_state_t  state_reg;
  crm_pkg::crm_state_t  state_next;

  localparam logic [2:0] WCNT_LAST = 3'(crm_pkg::WAIT_RESAMPLE - 1);
  localparam logic [3:0] REL_OUT   = 4'(crm_pkg::RESET_OUT_DELAY * 2);
  localparam logic [3:0] REL_STRAP = 4'(crm_pkg::STRAP_WINDOW * 2);
  localparam logic [3:0] REL_FETCH = 4'(crm_pkg::FETCH_DELAY_CLK * 2);

  wire  clk_rise   = ce & ~clk_div_reg;                        // Output rises next edge
  wire  init_act   = ~init_sync;
  wire  init_rel   = init_sync & ~init_sync_d_reg;
  wire  strap_lvl  = strap_driven ? strap_in : 1'h1;           // [R10]
  wire  wait_gate  = ~ext_mode_reg & strap_lvl;                // [R11]
  wire  sample_now = (wait_cnt_reg == WCNT_LAST);

  crm_sync #(
    .STAGES (crm_pkg::SYNC_STAGES),
    .INIT   (1'h0)
  ) u_init_sync (
    .mclk   (mclk),
    .reset  (reset),
    .ce     (ce),
    .d_in   (external_init_n),
    .q_out  (init_sync)
  ); // [R5]

  // Divider never stops for init or hold
  always_ff @(posedge mclk) begin
    if (reset) begin
      clk_div_reg <= 1'h0;
    end else if (ce) begin
      clk_div_reg <= ~clk_div_reg; // [R1] [R2] [R3] [R18]
    end
  end

  assign system_clock_out = clk_div_reg;
  assign osc_feedback_out = ~clk_div_reg;

  always_ff @(posedge mclk) begin
    if (reset) begin
      init_sync_d_reg <= 1'h0;
    end else if (ce) begin
      init_sync_d_reg <= init_sync;
    end
  end

  // Oscillator edges since release; two per output clock
  assign rel_cnt_next = init_act ? crm_pkg::CNT_ZERO :
                        (rel_cnt_reg == REL_FETCH) ? rel_cnt_reg : rel_cnt_reg + crm_pkg::CNT_ONE;

  always_ff @(posedge mclk) begin
    if (reset) begin
      rel_cnt_reg <= crm_pkg::CNT_ZERO;
    end else if (ce) begin
      rel_cnt_reg <= rel_cnt_next; // [R19]
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      reset_out_reg <= 1'h1;
    end else if (ce) begin
      if (init_act) begin
        reset_out_reg <= 1'h1;
      end else if (clk_rise && rel_cnt_reg >= REL_OUT - crm_pkg::CNT_ONE) begin
        reset_out_reg <= 1'h0; // [R16]
      end
    end
  end

  assign reset_out = reset_out_reg;

  // Strap sampled at release and again four output clocks later
  always_ff @(posedge mclk) begin
    if (reset) begin
      strap_hi_reg <= 1'h0;
      ext_mode_reg <= 1'h0;
    end else if (ce) begin
      if (init_act) begin
        strap_hi_reg <= 1'h0;
        ext_mode_reg <= 1'h0; // [R9]
      end else if (init_rel) begin
        strap_hi_reg <= strap_lvl; // [R8]
      end else if (rel_cnt_reg == REL_STRAP - crm_pkg::CNT_ONE) begin
        ext_mode_reg <= strap_hi_reg & ~strap_lvl; // [R8] [R17]
      end
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      crm_pkg::CRM_RESET: begin
        if (!init_act) begin
          state_next = crm_pkg::CRM_RELEASE;
        end
      end
      crm_pkg::CRM_RELEASE: begin
        if (rel_cnt_reg == REL_FETCH - crm_pkg::CNT_ONE) begin
          state_next = crm_pkg::CRM_RUN; // [R6]
        end
      end
      crm_pkg::CRM_RUN: begin
        if (pause_start && wait_gate) begin
          state_next = crm_pkg::CRM_PAUSED; // [R12]
        end
      end
      crm_pkg::CRM_PAUSED: begin
        if (sample_now && !wait_gate) begin
          state_next = crm_pkg::CRM_RUN; // [R13]
        end
      end
      default: begin
        state_next = crm_pkg::CRM_RESET;
      end
    endcase
    if (init_act) begin
      state_next = crm_pkg::CRM_RESET; // [R4]
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg    <= crm_pkg::CRM_RESET;
      wait_cnt_reg <= crm_pkg::WCNT_ZERO;
      fetch_reg    <= 1'h0;
    end else if (ce) begin
      state_reg    <= state_next;
      fetch_reg    <= (state_reg == crm_pkg::CRM_RELEASE) && (state_next == crm_pkg::CRM_RUN);
      if (state_reg != crm_pkg::CRM_PAUSED || sample_now) begin
        wait_cnt_reg <= crm_pkg::WCNT_ZERO;
      end else begin
        wait_cnt_reg <= wait_cnt_reg + crm_pkg::WCNT_ONE; // [R13]
      end
    end
  end

  assign irq_service = (state_reg == crm_pkg::CRM_PAUSED) & irq_pending; // [R14]

  assign status.extended_mode = ext_mode_reg;
  assign status.fetch_start   = fetch_reg;
  assign status.core_run      = (state_reg == crm_pkg::CRM_RUN);
  assign status.suspended     = (state_reg == crm_pkg::CRM_PAUSED);
  assign status.coproc_busy   = ext_mode_reg & strap_lvl; // [R15]

  property p_clk_toggle;
    @(posedge mclk) disable iff (reset) ce |=> system_clock_out != $past(system_clock_out);
  endproperty
  a_clk_toggle: assert property (p_clk_toggle) else $error("clock output did not toggle"); // [R1]
  property p_fb_inverse;
    @(posedge mclk) disable iff (reset) osc_feedback_out != system_clock_out;
  endproperty
  a_fb_inverse: assert property (p_fb_inverse) else $error("feedback drive not inverse of clock output"); // [R1]
  property p_duty;
    @(posedge mclk) disable iff (reset)
      (ce && !system_clock_out) ##1 (ce && system_clock_out) |=> !system_clock_out;
  endproperty
  a_duty: assert property (p_duty) else $error("clock output high and low times differ"); // [R2]
  property p_clk_during_reset;
    @(posedge mclk) disable iff (reset) (ce && init_act) |=> system_clock_out != $past(system_clock_out);
  endproperty
  a_clk_during_reset: assert property (p_clk_during_reset) else $error("clock stalled in init"); // [R3]
  property p_init_idle;
    @(posedge mclk) disable iff (reset) (ce && init_act) |=> state_reg == crm_pkg::CRM_RESET && reset_out;
  endproperty
  a_init_idle: assert property (p_init_idle) else $error("init did not force idle"); // [R4]
  property p_fetch_time;
    @(posedge mclk) disable iff (reset)
      (ce && init_rel) ##1 ce[*8] |-> ##[4:6] fetch_reg || init_act;
  endproperty
  a_fetch_time: assert property (p_fetch_time) else $error("fetch start out of window"); // [R6]
  property p_reset_out_hold;
    @(posedge mclk) disable iff (reset) (ce && init_rel) |=> reset_out [*2];
  endproperty
  a_reset_out_hold: assert property (p_reset_out_hold) else $error("reset output dropped early"); // [R16]
  property p_legacy_on_low;
    @(posedge mclk) disable iff (reset) (ce && init_rel && !strap_lvl) |=> !ext_mode_reg [*8];
  endproperty
  a_legacy_on_low: assert property (p_legacy_on_low) else $error("extended mode without strap high"); // [R8]
  property p_suspend;
    @(posedge mclk) disable iff (reset)
      (ce && state_reg == crm_pkg::CRM_RUN && pause_start && wait_gate && !init_act) |=> status.suspended;
  endproperty
  a_suspend: assert property (p_suspend) else $error("pause with gate high did not suspend"); // [R12]
  property p_resample;
    @(posedge mclk) disable iff (reset) (status.suspended && !wait_gate && ce) [*5] |=> !status.suspended;
  endproperty
  a_resample: assert property (p_resample) else $error("wait gate not resampled in five clocks"); // [R13]
  property p_irq;
    @(posedge mclk) disable iff (reset) (status.suspended && irq_pending) |-> irq_service;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not serviced while suspended"); // [R14]

  // Synchroniser latency and init clearing
  property p_sync_delay;
    @(posedge mclk) disable iff (reset) (ce && !external_init_n) ##1 ce |=> init_act;
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("init not seen two edges after pin low"); // [R5]
  property p_init_clears;
    @(posedge mclk) disable iff (reset)
      (ce && init_act) |=> !status.extended_mode && !status.fetch_start && !status.suspended;
  endproperty
  a_init_clears: assert property (p_init_clears) else $error("init left mode, fetch or wait active"); // [R4]

  // Fetch start and reset output timing
  property p_fetch_pulse;
    @(posedge mclk) disable iff (reset) (ce && fetch_reg) |=> !fetch_reg;
  endproperty
  a_fetch_pulse: assert property (p_fetch_pulse) else $error("fetch start longer than one cycle"); // [R6]
  property p_fetch_in_run;
    @(posedge mclk) disable iff (reset) fetch_reg |-> status.core_run;
  endproperty
  a_fetch_in_run: assert property (p_fetch_in_run) else $error("fetch start without run state"); // [R6]
  property p_no_early_fetch;
    @(posedge mclk) disable iff (reset) (ce && init_rel) |=> !fetch_reg [*8];
  endproperty
  a_no_early_fetch: assert property (p_no_early_fetch) else $error("fetch started too soon after release"); // [R6]
  property p_reset_out_release;
    @(posedge mclk) disable iff (reset)
      (ce && init_rel) ##1 (ce && !init_act) [*6] |=> !reset_out;
  endproperty
  a_reset_out_release: assert property (p_reset_out_release) else $error("reset output held too long"); // [R16]
  property p_reset_out_edge;
    @(posedge mclk) disable iff (reset) $fell(reset_out) |-> system_clock_out;
  endproperty
  a_reset_out_edge: assert property (p_reset_out_edge) else $error("reset output fell off clock rise"); // [R16]

  // Mode strap decision
  property p_ext_select;
    @(posedge mclk) disable iff (reset)
      (ce && init_rel && strap_lvl) ##1 (ce && !init_act) [*6] ##1 (ce && !init_act && !strap_lvl)
      |=> status.extended_mode;
  endproperty
  a_ext_select: assert property (p_ext_select) else $error("strap high then low did not select extended"); // [R8]
  property p_legacy_select;
    @(posedge mclk) disable iff (reset)
      (ce && init_rel) ##1 (ce && !init_act) [*6] ##1 (ce && !init_act && strap_lvl)
      |=> !status.extended_mode;
  endproperty
  a_legacy_select: assert property (p_legacy_select) else $error("strap high late still gave extended"); // [R8]
  property p_mode_frozen;
    @(posedge mclk) disable iff (reset) (ce && status.core_run && !init_act) |=> $stable(status.extended_mode);
  endproperty
  a_mode_frozen: assert property (p_mode_frozen) else $error("mode changed while running"); // [R8]

  // Wait gate and busy behaviour
  property p_pullup_gate;
    @(posedge mclk) disable iff (reset)
      (ce && !strap_driven && !ext_mode_reg && status.core_run && pause_start && !init_act) |=> status.suspended;
  endproperty
  a_pullup_gate: assert property (p_pullup_gate) else $error("floating strap did not read high"); // [R10]
  property p_no_wait_ext;
    @(posedge mclk) disable iff (reset) (ce && ext_mode_reg && pause_start && status.core_run) |=> !status.suspended;
  endproperty
  a_no_wait_ext: assert property (p_no_wait_ext) else $error("suspended in extended mode"); // [R15]
  property p_busy_legacy;
    @(posedge mclk) disable iff (reset) !ext_mode_reg |-> !status.coproc_busy;
  endproperty
  a_busy_legacy: assert property (p_busy_legacy) else $error("busy shown in legacy mode"); // [R15]
  property p_wait_cnt_bound;
    @(posedge mclk) disable iff (reset) wait_cnt_reg <= WCNT_LAST;
  endproperty
  a_wait_cnt_bound: assert property (p_wait_cnt_bound) else $error("resample counter out of range"); // [R13]
  property p_stay_gate_high;
    @(posedge mclk) disable iff (reset) (ce && status.suspended && wait_gate && !init_act) |=> status.suspended;
  endproperty
  a_stay_gate_high: assert property (p_stay_gate_high) else $error("resumed with gate high"); // [R13]
  property p_resume_on_sample;
    @(posedge mclk) disable iff (reset)
      (ce && status.suspended && sample_now && !wait_gate && !init_act) |=> status.core_run;
  endproperty
  a_resume_on_sample: assert property (p_resume_on_sample) else $error("no resume after low sample"); // [R13]
  property p_no_irq_run;
    @(posedge mclk) disable iff (reset) !status.suspended |-> !irq_service;
  endproperty
  a_no_irq_run: assert property (p_no_irq_run) else $error("interrupt service outside suspend"); // [R14]

  c_ext_mode: cover property (@(posedge mclk) $rose(ext_mode_reg));
  c_fetch: cover property (@(posedge mclk) fetch_reg);
  c_suspend_resume: cover property (@(posedge mclk) status.suspended ##[1:20] status.core_run);
  c_busy: cover property (@(posedge mclk) status.coproc_busy);
  c_reset_release: cover property (@(posedge mclk) $fell(reset_out));
endmodule // crm_top

//--- tb/crm_partner.sv
// Reset source and strap pin driver facing the block
`timescale 1ns/1ps
module crm_partner (
  input  wire logic       mclk,            // Oscillator clock
  input  wire logic       hold_init,       // Request to hold init active
  input  wire logic [1:0] strap_mode,      // 0 drive, 1 float, 2 tie to reset_out
  input  wire logic       strap_lvl,       // Level driven in mode 0
  input  wire logic       reset_out,       // Block reset output
  output logic            external_init_n, // Init to block, active low
  output logic            strap_in,        // Strap pin level
  output logic            strap_driven     // Outside driver present
);
  logic [3:0] low_cnt_reg;

  initial begin
    external_init_n = 1'h0;
    low_cnt_reg = 4'h0;
  end

  // Release only after a long enough low time; rising edge keeps bench writes race free
  always @(posedge mclk) begin
    if (hold_init) external_init_n <= 1'h0;
    else if (low_cnt_reg == 4'hB) external_init_n <= 1'h1;
    low_cnt_reg <= external_init_n ? 4'h0 : (low_cnt_reg == 4'hB) ? low_cnt_reg : low_cnt_reg + 4'h1;
  end

  assign strap_driven = (strap_mode != 2'h1);
  assign strap_in = (strap_mode == 2'h2) ? reset_out : (strap_mode == 2'h1) ? 1'h1 : strap_lvl;
endmodule  // crm_partner

//--- tb/test_clock_reset_mode_select.sv
// Self-checking bench for the clock, reset and mode select block
`timescale 1ns/1ps
module test_clock_reset_mode_select;
  logic                 mclk, reset, pause_start, irq_pending, hold_init, strap_lvl;
  logic [1:0]           strap_mode;
  logic                 init_n, strap_in, strap_driven, sys_clk, fb, reset_out, irq_service;
  crm_pkg::crm_status_t status;
  int                   n_fail, tests_run, k;
  typedef struct {logic [1:0] m; logic a; logic b; logic ext;} crm_row_t;
  crm_row_t rows [6] = '{'{2'h0, 1'h1, 1'h0, 1'h1}, '{2'h0, 1'h1, 1'h1, 1'h0}, '{2'h0, 1'h0, 1'h0, 1'h0},
                         '{2'h0, 1'h0, 1'h1, 1'h0}, '{2'h1, 1'h1, 1'h1, 1'h0}, '{2'h2, 1'h0, 1'h0, 1'h1}};

  crm_top uut (.mclk(mclk), .reset(reset), .ce(1'h1), .external_init_n(init_n), .strap_in(strap_in),
    .strap_driven(strap_driven), .pause_start(pause_start), .irq_pending(irq_pending), .osc_feedback_out(fb),
    .system_clock_out(sys_clk), .reset_out(reset_out), .irq_service(irq_service), .status(status));
  crm_partner far (.mclk(mclk), .hold_init(hold_init), .strap_mode(strap_mode), .strap_lvl(strap_lvl),
    .reset_out(reset_out), .external_init_n(init_n), .strap_in(strap_in), .strap_driven(strap_driven));

  task automatic check(input string name, input logic seen, input logic exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %b seen %b", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Init cycle with strap level a at release and b four clocks on
  task automatic boot(input crm_row_t r);
    int   t_rst, t_go;
    logic prev;
    t_rst = -1;
    t_go = -1;
    strap_mode = r.m;
    strap_lvl = r.a;
    hold_init = 1'h1;
    repeat (4) @(negedge mclk);
    prev = sys_clk;
    @(negedge mclk);
    check("clk_div", sys_clk, ~prev);
    check("osc_fb", fb, ~sys_clk);
    check("rst_held", reset_out, 1'h1);
    hold_init = 1'h0;
    for (int i = 0; i < 20 && init_n !== 1'h1; i++) @(negedge mclk);
    if (init_n !== 1'h1) begin
      n_fail++;
      wrap_up();
    end
    for (int t = 0; t < 40; t++) begin
      if (t == 4) strap_lvl = r.b;
      if (reset_out === 1'h0 && t_rst < 0) t_rst = t;
      if (status.fetch_start === 1'h1) t_go = t;
      @(negedge mclk);
    end
    check("rst_delay", t_rst inside {[3:8]}, 1'h1);
    check("fetch_delay", t_go inside {[12:20]}, 1'h1);
    check("mode", status.extended_mode, r.ext);
    check("run", status.core_run, 1'h1);
  endtask

  task automatic pulse_pause();
    pause_start = 1'h1;
    @(negedge mclk);
    pause_start = 1'h0;
  endtask

  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    reset = 1'h1;
    pause_start = 1'h0;
    irq_pending = 1'h0;
    hold_init = 1'h1;
    strap_mode = 2'h0;
    strap_lvl = 1'h1;
    n_fail = 0;
    tests_run = 0;
    repeat (8) @(negedge mclk);
    reset = 1'h0;
    foreach (rows[i]) begin
      boot(rows[i]);
      $display("test mode row %0d done", i);
    end
    // Legacy mode, gate held high
    boot(rows[1]);
    pulse_pause();
    check("suspend", status.suspended, 1'h1);
    irq_pending = 1'h1;
    @(negedge mclk);
    check("irq", irq_service, 1'h1);
    irq_pending = 1'h0;
    repeat (12) @(negedge mclk);
    check("stay", status.suspended, 1'h1);
    strap_lvl = 1'h0;
    for (k = 0; k < 12 && status.suspended !== 1'h0; k++) @(negedge mclk);
    check("resume", k <= 7 && status.core_run === 1'h1, 1'h1);
    $display("test wait gate done");
    // Floating strap reads high through the pull-up
    boot(rows[4]);
    pulse_pause();
    check("float", status.suspended, 1'h1);
    $display("test pull-up done");
    // Extended mode, strap is busy
    boot(rows[0]);
    strap_lvl = 1'h1;
    @(negedge mclk);
    check("busy", status.coproc_busy, 1'h1);
    pulse_pause();
    check("no_wait", status.suspended, 1'h0);
    hold_init = 1'h1;
    repeat (4) @(negedge mclk);
    check("abort_rst", reset_out, 1'h1);
    check("abort_mode", status.extended_mode, 1'h0);
    check("abort_run", status.core_run, 1'h0);
    $display("test extended and abort done");
    wrap_up();
  end
endmodule  // test_clock_reset_mode_select
